// ===== hdl/lsf_board.sv
// board end: signal mailbox and board status register
// assumes link-side inputs are synchronous to clk_i
module lsf_board
	import lsf_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	lsf_link_if.board        bus,
	input  wire logic        link_wr_i,
	input  wire logic [15:0] link_addr_i,
	input  wire logic [15:0] link_wdata_i,
	input  wire logic        signal_ready_irq_enable_i,
	input  wire logic        host_bus_request_i,
	input  wire logic        link_arbitrating_i,
	input  wire logic        link_block_i,
	input  wire logic        link_owned_i,
	input  wire logic        parity_fault_i,
	input  wire logic        deadlock_flag_i,
	input  wire logic        bus_fault_i,
	input  wire logic        host_access_timeout_i,
	input  wire logic        remote_irq_request_i,
	input  wire logic        host_request_irq_i,
	input  wire logic        master_exception_irq_i,
	input  wire logic        terminal_count_irq_i,
	input  wire logic        link_owned_irq_i,
	output logic             mbox_full_o
);
	// ****************************************
	// mailbox
	// ****************************************
	logic        push;
	logic        pop;
	logic        rd_mbox;
	logic        rd_stat;
	logic [15:0] head;
	logic        empty;
	logic        signal_ready_flag;
	assign push    = link_wr_i && (link_addr_i == LSF_LINK_MBOX_ADDR);
	assign rd_mbox = bus.io_rd && bus.io_word && (bus.io_addr == LSF_OFS_MAILBOX);
	assign rd_stat = bus.io_rd && (bus.io_addr == LSF_OFS_STATUS);
	assign pop     = rd_mbox;
	lsf_fifo #(
		.WIDTH (LSF_DATA_W),
		.DEPTH (LSF_FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_b_i     (rst_b_i),
		.push_i      (push),
		.push_data_i (link_wdata_i),
		.pop_i       (pop),
		.head_o      (head),
		.empty_o     (empty),
		.full_o      (mbox_full_o)
	);
	// ready is just non-empty: a write sets it, the last pop clears it
	assign signal_ready_flag = !empty;
	assign bus.host_irq = signal_ready_flag && signal_ready_irq_enable_i;
	// ****************************************
	// sticky faults, cleared on status read
	// ****************************************
	logic [3:0] fault_reg;
	logic [3:0] fault_set;
	assign fault_set = {parity_fault_i, deadlock_flag_i, bus_fault_i, host_access_timeout_i};
	// a fault arriving in the read cycle survives the clear
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			fault_reg <= LSF_FAULTS_CLEAR;
		else if (rd_stat)
			fault_reg <= fault_set;
		else
			fault_reg <= fault_reg | fault_set;
	end
	// ****************************************
	// status word assembly
	// ****************************************
	logic [15:0] status;
	always_comb
	begin
		status = '0;
		status[LSF_ST_HOST_REQ]   = host_bus_request_i;
		status[LSF_ST_ARB]        = link_arbitrating_i;
		status[LSF_ST_BLOCK]      = link_block_i && link_owned_i;
		status[LSF_ST_OWNED]      = link_owned_i;
		status[LSF_ST_PARITY]     = fault_reg[3];
		status[LSF_ST_DEADLOCK]   = fault_reg[2];
		status[LSF_ST_BUSFAULT]   = fault_reg[1];
		status[LSF_ST_TIMEOUT]    = fault_reg[0];
		status[LSF_ST_RIRQ_HI]    = remote_irq_request_i;
		status[LSF_ST_HOSTREQIRQ] = host_request_irq_i;
		status[LSF_ST_RIRQ_LO]    = remote_irq_request_i;
		status[LSF_ST_MEXC]       = master_exception_irq_i;
		status[LSF_ST_TC]         = terminal_count_irq_i;
		status[LSF_ST_OWNIRQ]     = link_owned_irq_i;
		status[LSF_ST_SIGNAL_READY_FLAG]     = signal_ready_flag;
		status[LSF_ST_SUMMARY]    = |status[LSF_ST_RIRQ_HI:LSF_ST_SIGNAL_READY_FLAG];
	end
	// ****************************************
	// registered read answer
	// ****************************************
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			bus.io_rdata  <= '0;
			bus.io_rvalid <= 1'b0;
		end
		else
		begin
			bus.io_rvalid <= bus.io_rd;
			if (rd_mbox)
				bus.io_rdata <= {head[7:0], head[15:8]};
			else if (rd_stat)
				bus.io_rdata <= status;
			else if (bus.io_rd)
				bus.io_rdata <= '0;                       // unmapped or 8-bit mailbox
		end
	end
endmodule

// ===== hdl/lsf_pkg.sv
// package for the link signal mailbox and board status block
// assumes one 20 MHz clock shared by both ends and the testbench
package lsf_pkg;
	// ****************************************
	// host port map
	// ****************************************
	localparam logic [3:0]  LSF_OFS_MAILBOX = 4'h8;  // base plus 08
	localparam logic [3:0]  LSF_OFS_STATUS  = 4'hA;  // base plus 0A
	localparam logic [15:0] LSF_LINK_MBOX_ADDR = 16'hC008;
	localparam int          LSF_FIFO_DEPTH  = 8;
	localparam int          LSF_DATA_W      = 16;
	// ****************************************
	// status bit positions
	// ****************************************
	localparam int LSF_ST_HOST_REQ   = 15;
	localparam int LSF_ST_ARB        = 14;
	localparam int LSF_ST_BLOCK      = 13;
	localparam int LSF_ST_OWNED      = 12;
	localparam int LSF_ST_PARITY     = 11;
	localparam int LSF_ST_DEADLOCK   = 10;
	localparam int LSF_ST_BUSFAULT   = 9;
	localparam int LSF_ST_TIMEOUT    = 8;
	localparam int LSF_ST_SUMMARY    = 7;
	localparam int LSF_ST_RIRQ_HI    = 6;
	localparam int LSF_ST_HOSTREQIRQ = 5;
	localparam int LSF_ST_RIRQ_LO    = 4;
	localparam int LSF_ST_MEXC       = 3;
	localparam int LSF_ST_TC         = 2;
	localparam int LSF_ST_OWNIRQ     = 1;
	localparam int LSF_ST_SIGNAL_READY_FLAG     = 0;
	localparam logic [3:0] LSF_FAULTS_CLEAR = 4'h0;
	// master-side host states
	typedef enum logic [2:0]
	{
		LSF_H_IDLE = 3'b001,
		LSF_H_READ = 3'b010,
		LSF_H_DONE = 3'b100
	} lsf_host_state_e;
endpackage

// ===== hdl/lsf_link_if.sv
// interface joining the board end and the host end
// assumes both ends run on the same clock and reset
interface lsf_link_if
	import lsf_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i
);
	logic [3:0]  io_addr;     // host port offset
	logic        io_rd;       // one-cycle read strobe
	logic        io_word;     // 1 = 16-bit access, 0 = 8-bit
	logic [15:0] io_rdata;    // read data, valid cycle after strobe
	logic        io_rvalid;   // read answer pulse
	logic        host_irq;    // host interrupt request level
	modport board (input io_addr, io_rd, io_word, output io_rdata, io_rvalid, host_irq);
	modport host  (output io_addr, io_rd, io_word, input io_rdata, io_rvalid, host_irq);
endinterface

// ===== hdl/lsf_fifo.sv
// signal mailbox store: eight words of sixteen bits
// assumes push and pop come from the same clock domain
module lsf_fifo
	import lsf_pkg::*;
#(
	parameter int WIDTH = LSF_DATA_W,
	parameter int DEPTH = LSF_FIFO_DEPTH
)
(
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             push_i,
	input  wire logic [WIDTH-1:0] push_data_i,
	input  wire logic             pop_i,
	output logic      [WIDTH-1:0] head_o,
	output logic                  empty_o,
	output logic                  full_o
);
	localparam int AW = $clog2(DEPTH);
	// elaboration check: pointer wrap only works for a power-of-two depth
	if (DEPTH < 2 || (1 << AW) != DEPTH)
	begin : g_depth_check
		$error("lsf_fifo depth must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             do_push;
	logic             do_pop;
	// a push into a full store is dropped; empty pop leaves state alone
	assign do_push = push_i && !full_o;
	assign do_pop  = pop_i && !empty_o;
	assign empty_o = (count_reg == '0);
	assign full_o  = (count_reg == (AW+1)'(DEPTH));
	assign head_o  = mem[rd_ptr_reg];
	// storage array
	always_ff @(posedge clk_i)
	begin
		if (do_push)
			mem[wr_ptr_reg] <= push_data_i;
	end
	// pointers and occupancy
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			if (do_push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (do_pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			count_reg <= count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
endmodule

// ===== hdl/lsf_host.sv
// host end: issues port reads for software and returns the data
// assumes the board answers one cycle after each strobe
module lsf_host
	import lsf_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	lsf_link_if.host         bus,
	input  wire logic        req_i,
	input  wire logic [3:0]  req_addr_i,
	input  wire logic        req_word_i,
	output logic             req_ready_o,
	output logic [15:0]      rsp_data_o,
	output logic             rsp_valid_o,
	output logic             irq_o
);
	lsf_host_state_e state_reg;
	logic            init_done_reg;
	logic [3:0]      addr_reg;
	logic            word_reg;
	// ****************************************
	// request sequencer
	// ****************************************
	// first action after reset is one 16-bit mailbox read, which pops at most one word from the store
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_reg     <= LSF_H_IDLE;
			init_done_reg <= 1'b0;
			addr_reg      <= '0;
			word_reg      <= 1'b0;
		end
		else
		begin
			unique case (state_reg)
				LSF_H_IDLE:
				begin
					if (!init_done_reg)
					begin
						addr_reg  <= LSF_OFS_MAILBOX;
						word_reg  <= 1'b1;
						state_reg <= LSF_H_READ;
					end
					else if (req_i)
					begin
						addr_reg  <= req_addr_i;
						word_reg  <= req_word_i;
						state_reg <= LSF_H_READ;
					end
				end
				LSF_H_READ:
					state_reg <= LSF_H_DONE;
				LSF_H_DONE:
					if (bus.io_rvalid)
					begin
						init_done_reg <= 1'b1;
						state_reg     <= LSF_H_IDLE;
					end
			endcase
		end
	end
	assign bus.io_rd   = (state_reg == LSF_H_READ);
	assign bus.io_addr = addr_reg;
	assign bus.io_word = word_reg;
	assign req_ready_o = (state_reg == LSF_H_IDLE) && init_done_reg;
	// interrupt passed to software so it can drain promptly; are software duties
	assign irq_o = bus.host_irq;
	// ****************************************
	// response capture
	// ****************************************
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rsp_data_o  <= '0;
			rsp_valid_o <= 1'b0;
		end
		else
		begin
			rsp_valid_o <= bus.io_rvalid && init_done_reg;
			if (bus.io_rvalid)
				rsp_data_o <= bus.io_rdata;
		end
	end
endmodule

// ===== verif/lsf_properties.sv
// checker for the host port between board and host ends
// assumes tb_top instantiates it beside lsf_link_if
module lsf_properties
	import lsf_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	input wire logic [3:0]  io_addr,
	input wire logic        io_rd,
	input wire logic        io_word,
	input wire logic [15:0] io_rdata,
	input wire logic        io_rvalid,
	input wire logic        host_irq
);
	// ****
	// host port properties
	// ****
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	sequence s_stat_rd;
		io_rd && io_addr == LSF_OFS_STATUS;
	endsequence
	sequence s_irq_stat_rd;
		io_rd && io_addr == LSF_OFS_STATUS && host_irq;
	endsequence
	sequence s_answer;
		io_rvalid ##1 !io_rvalid;
	endsequence
	AST_ANSWER: assert property (io_rd |=> io_rvalid)
		else $error("missing answer");
	AST_NO_SPUR: assert property (!io_rd |=> !io_rvalid)
		else $error("answer without strobe");
	AST_ONE_PULSE: assert property (io_rvalid |-> s_answer)
		else $error("answer too long");
	AST_HOLD: assert property (!io_rd |=> $stable(io_rdata))
		else $error("read data moved");
	AST_SUMMARY: assert property (s_stat_rd |=> io_rdata[7] == |io_rdata[6:0])
		else $error("summary bit wrong");
	AST_MIRROR: assert property (s_stat_rd |=> io_rdata[6] == io_rdata[4])
		else $error("remote irq copies differ");
	AST_IRQ_RDY: assert property (s_irq_stat_rd |=> io_rdata[0])
		else $error("irq without ready");
	AST_BYTE_MBOX: assert property (io_rd && io_addr == LSF_OFS_MAILBOX && !io_word
		|=> io_rdata == 16'h0000) else $error("byte mailbox read data");
	AST_UNMAPPED: assert property (io_rd && io_addr != LSF_OFS_MAILBOX
		&& io_addr != LSF_OFS_STATUS |=> io_rdata == 16'h0000) else $error("unmapped data");
endmodule

// ===== verif/tb_top.sv
// testbench: board and host ends joined by the link interface
// assumes the hdl files are compiled first
module tb_top
	import lsf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i, rst_b_i, link_wr, irq_en, req, req_word;
	logic        mbox_full, req_ready, rsp_valid, irq;
	logic [3:0]  req_addr, lvl, flt;
	logic [4:0]  irqs;
	logic [15:0] link_addr, link_wdata, rsp_data, rd_data;
	int          errors = 0;
	int          total_checks = 0;
	// ****
	// ends, interface and checker
	// ****
	lsf_link_if u_lsf_link_if (.clk_i(clk_i), .rst_b_i(rst_b_i));
	lsf_board u_lsf_board (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus(u_lsf_link_if.board),
		.link_wr_i(link_wr), .link_addr_i(link_addr), .link_wdata_i(link_wdata),
		.signal_ready_irq_enable_i(irq_en), .host_bus_request_i(lvl[3]),
		.link_arbitrating_i(lvl[2]), .link_block_i(lvl[1]), .link_owned_i(lvl[0]),
		.parity_fault_i(flt[3]), .deadlock_flag_i(flt[2]), .bus_fault_i(flt[1]),
		.host_access_timeout_i(flt[0]), .remote_irq_request_i(irqs[4]),
		.host_request_irq_i(irqs[3]), .master_exception_irq_i(irqs[2]),
		.terminal_count_irq_i(irqs[1]), .link_owned_irq_i(irqs[0]), .mbox_full_o(mbox_full));
	lsf_host u_lsf_host (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus(u_lsf_link_if.host),
		.req_i(req), .req_addr_i(req_addr), .req_word_i(req_word), .req_ready_o(req_ready),
		.rsp_data_o(rsp_data), .rsp_valid_o(rsp_valid), .irq_o(irq));
	lsf_properties u_lsf_properties (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.io_addr(u_lsf_link_if.io_addr), .io_rd(u_lsf_link_if.io_rd),
		.io_word(u_lsf_link_if.io_word), .io_rdata(u_lsf_link_if.io_rdata),
		.io_rvalid(u_lsf_link_if.io_rvalid), .host_irq(u_lsf_link_if.host_irq));
	// ****
	// shared tasks
	// ****
	// expected status word: bit 13 needs block and ownership together
	function automatic logic [15:0] st_exp(input logic rdy, input logic [3:0] f);
		logic [6:0] lo;
		lo = {irqs[4], irqs[3], irqs[4], irqs[2], irqs[1], irqs[0], rdy};
		return {lvl[3], lvl[2], lvl[1] & lvl[0], lvl[0], f, |lo, lo};
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	// request held until taken, answer waited for under a bound
	task automatic host_rd(input logic [3:0] a, input logic w);
		int n;
		n = 0;
		@(posedge clk_i);
		req <= 1'b1;
		req_addr <= a;
		req_word <= w;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (req_ready !== 1'b1 && n < 40);
		req <= 1'b0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (rsp_valid !== 1'b1 && n < 80);
		rd_data = rsp_data;
		if (n >= 80)
			errors++;
	endtask
	task automatic push(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_i);
		link_wr <= 1'b1;
		link_addr <= a;
		link_wdata <= d;
		@(posedge clk_i);
		link_wr <= 1'b0;
	endtask
	task automatic pulse(input logic [3:0] m);
		@(posedge clk_i);
		flt <= m;
		@(posedge clk_i);
		flt <= 4'h0;
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_mailbox();
		logic [15:0] d;
		@(posedge clk_i);
		irq_en <= 1'b1;
		for (int i = 0; i < 9; i++)
			push(LSF_LINK_MBOX_ADDR, 16'h1200 + 16'(i) * 16'h0101);
		push(16'hC00A, 16'hFFFF);
		@(negedge clk_i);
		chk("full", 16'h0001, mbox_full);
		chk("irq", 16'h0001, irq);
		@(posedge clk_i);
		irq_en <= 1'b0;
		@(negedge clk_i);
		chk("irq masked", 16'h0000, irq);
		@(posedge clk_i);
		irq_en <= 1'b1;
		host_rd(LSF_OFS_MAILBOX, 1'b0);
		chk("byte mbox", 16'h0000, rd_data);
		for (int i = 0; i < 8; i++)
		begin
			d = 16'h1200 + 16'(i) * 16'h0101;
			host_rd(LSF_OFS_MAILBOX, 1'b1);
			chk("mbox", {d[7:0], d[15:8]}, rd_data);
		end
		@(negedge clk_i);
		chk("irq empty", 16'h0000, irq);
		chk("not full", 16'h0000, mbox_full);
		host_rd(LSF_OFS_STATUS, 1'b1);
		chk("status empty", st_exp(1'b0, 4'h0), rd_data);
		host_rd(LSF_OFS_MAILBOX, 1'b1);
		push(LSF_LINK_MBOX_ADDR, 16'hABCD);
		host_rd(LSF_OFS_STATUS, 1'b1);
		chk("status ready", st_exp(1'b1, 4'h0), rd_data);
		host_rd(LSF_OFS_MAILBOX, 1'b1);
		chk("after empty read", 16'hCDAB, rd_data);
	endtask
	task automatic t_status();
		logic [15:0] e;
		@(posedge clk_i);
		lvl <= 4'hB;
		irqs <= 5'h15;
		pulse(4'hF);
		host_rd(LSF_OFS_STATUS, 1'b1);
		chk("faults set", st_exp(1'b0, 4'hF), rd_data);
		host_rd(LSF_OFS_STATUS, 1'b1);
		chk("faults clear", st_exp(1'b0, 4'h0), rd_data);
		@(posedge clk_i);
		lvl <= 4'h6;
		irqs <= 5'h0A;
		for (int k = 0; k < 4; k++)
		begin
			pulse(4'h1 << k);
			host_rd(LSF_OFS_STATUS, 1'b1);
			chk("one fault", st_exp(1'b0, 4'h1 << k), rd_data);
		end
		host_rd(LSF_OFS_STATUS, 1'b0);
		e = st_exp(1'b0, 4'h0);
		chk("byte status", {8'h00, e[7:0]}, {8'h00, rd_data[7:0]});
	endtask
	task automatic t_unmapped();
		host_rd(4'h0, 1'b1);
		chk("offset 0", 16'h0000, rd_data);
		host_rd(4'hC, 1'b0);
		chk("offset C", 16'h0000, rd_data);
	endtask
	task automatic print_verdict();
		if (errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// clock of 50 ns
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// reset for three cycles, then the scenarios
	initial
	begin
		{rst_b_i, link_wr, irq_en, req, req_word, req_addr, lvl, flt, irqs} = '0;
		{link_addr, link_wdata} = '0;
		repeat (3) @(posedge clk_i);
		rst_b_i <= 1'b1;
		// host end issues one mailbox read itself right after reset, popping at most one word
		t_mailbox();
		t_status();
		t_unmapped();
		print_verdict();
	end
	// watchdog: scenarios need well under 2000 cycles
	initial
	begin
		#1000000;
		errors++;
		print_verdict();
	end
endmodule
